/* File: flash_cmd_cfg.svh */
// constants of the flash instruction block
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
`define OPC_WREN 8'h06
`define OPC_WRDI 8'h04
`define OPC_WRAP 8'h77
`define OPC_PROG 8'h02
`define OPC_QPROG 8'h32
`define OPC_SERASE 8'h20
`define OPC_DREAD 8'hBB
`define OPC_QREAD 8'hEB
`define OPC_WREAD 8'hE7
`define OPC_OREAD 8'hE3
`define OPC_BITS 5'h08
`define ADDR_BITS 5'h18
`define MODE_BITS 5'h08
`define DATA_BITS 5'h08
`define CONT_KEEP 2'h2
`define CTRL_LSB 4
`define WRAP_LSB 4
`define RST_QUAD 5'h08
`define RST_DUAL 5'h10
`define WRAP_RST 3'h7
`define SECTOR_MASK 24'hFFF000
`define DEV_BYTES 24'h400000
`define BLOCK_BYTES 24'h010000
`define SECTOR_BYTES 24'h001000
`define CLK_NS 25
`define PROG_NS 700000
`define SERASE_NS 45000000
`endif

/* File: flash_cmd_pkg.sv */
// types shared by the flash instruction block
package flash_cmd_pkg;
   typedef enum logic [2:0] {
      L_OPC = 3'h0,
      L_ADDR = 3'h1,
      L_MODE = 3'h2,
      L_DATA = 3'h3,
      L_END = 3'h4,
      L_SKIP = 3'h5
   } link_phase_e;
   typedef enum logic {
      C_IDLE = 1'h0,
      C_BUSY = 1'h1
   } core_state_e;
   typedef struct packed {
      logic [7:0] opc;
      logic [23:0] addr;
      logic [7:0] wrap_byte;
      logic ok;
   } frame_s;
   typedef struct packed {
      logic protect_complement_bit;
      logic sector_granularity_bit;
      logic top_bottom_select_bit;
      logic block_protect_high;
      logic block_protect_mid;
      logic block_protect_low;
   } protect_s;
   typedef struct packed {
      logic prog;
      logic erase;
      logic [23:0] addr;
   } array_cmd_s;
endpackage

/* File: flash_cmd.sv */
// instruction interpreter for wrap, continuous read, program and erase
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"

module flash_cmd
   import flash_cmd_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = (`PROG_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int unsigned ERASE_CYCLES =
      (`SERASE_NS + `CLK_NS - 1) / `CLK_NS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic quad_enable_bit,
   input wire protect_s protect,
   input wire logic [7:0] buf_idx,
   input wire logic rd_start,
   input wire logic [23:0] rd_start_addr,
   input wire logic rd_next,
   output logic busy_q,
   output logic write_enable_latch_q,
   output logic [2:0] wrap_setting_q,
   output logic cont_read_active_q,
   output array_cmd_s cmd_q,
   output logic op_done_q,
   output logic [23:0] rd_addr_q,
   output logic [7:0] buf_data_q,
   output logic buf_loaded_q
);

   // lanes used per link clock for an opcode in a given phase
   function automatic logic [2:0] lanes(
      input logic [7:0] opc,
      input link_phase_e ph
   );
      logic [2:0] w;
      w = 3'h1;
      if (ph != L_OPC) begin
         case (opc)
            `OPC_QPROG, `OPC_WRAP, `OPC_QREAD,
            `OPC_WREAD, `OPC_OREAD: w = 3'h4;
            `OPC_DREAD: w = 3'h2;
            default: w = 3'h1;
         endcase
      end
      return w;
   endfunction

   // opcodes that carry continuous read mode bits
   function automatic logic is_read(input logic [7:0] opc);
      return (opc == `OPC_DREAD) || (opc == `OPC_QREAD) ||
         (opc == `OPC_WREAD) || (opc == `OPC_OREAD);
   endfunction

   // true when the address lies in the protected region
   function automatic logic is_prot(
      input logic [23:0] a,
      input protect_s p
   );
      logic [2:0] bp;
      logic [2:0] sh;
      logic [23:0] size;
      logic [23:0] off;
      logic hit;
      bp = {p.block_protect_high, p.block_protect_mid,
         p.block_protect_low};
      sh = bp - 3'h1;
      off = a & (`DEV_BYTES - 24'h000001);
      if (p.sector_granularity_bit) begin
         size = `SECTOR_BYTES << ((sh > 3'h3) ? 3'h3 : sh);
      end else begin
         size = `BLOCK_BYTES << sh;
      end
      if (bp == 3'h0) begin
         hit = 1'b0;
      end else if (p.top_bottom_select_bit) begin
         hit = off < size;
      end else begin
         hit = off >= (`DEV_BYTES - size);
      end
      return hit ^ p.protect_complement_bit;
   endfunction

   // link-side state
   logic fresh_q;
   logic frame_clr;
   link_phase_e ph_q, ph_d;
   frame_s frm_q, frm_d;
   logic [23:0] acc_q, acc_d;
   logic [4:0] nbit_q, nbit_d;
   logic [7:0] idx_q, idx_d;
   logic cont_q, cont_d;
   logic [7:0] cont_opc_q, cont_opc_d;
   logic in_cont_q, in_cont_d;
   logic run_q, run_d;
   logic [4:0] ones_q, ones_d;
   logic [7:0] buf_q [256];
   logic [7:0] buf_d [256];
   logic [255:0] loaded_q, loaded_d;
   logic bsy_s1_q, bsy_s2_q;

   // core-side state
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic cr_s1_q;
   logic cs_rise;
   core_state_e st_q, st_d;
   logic [23:0] cnt_q, cnt_d;
   logic busy_d;
   logic wel_d;
   logic [2:0] wrap_d;
   array_cmd_s cmd_d;
   logic done_d;
   logic [23:0] rd_addr_d;
   logic [7:0] buf_data_d;
   logic buf_loaded_d;
   logic prot_hit;

   // cs high, or reset, arms a fresh frame for the next sclk edge
   assign frame_clr = cs_n | ~reset_n;

   always_ff @(posedge link_sclk or posedge frame_clr) begin
      if (frame_clr) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   // busy level carried into the link domain
   always_ff @(posedge link_sclk or negedge reset_n) begin
      if (!reset_n) begin
         bsy_s1_q <= 1'b0;
         bsy_s2_q <= 1'b0;
      end else begin
         bsy_s1_q <= busy_q;
         bsy_s2_q <= bsy_s1_q;
      end
   end

   // link decoder: one step per sclk rising edge
   always_comb begin
      logic [2:0] w;
      logic [4:0] lim;
      ph_d = ph_q;
      frm_d = frm_q;
      acc_d = acc_q;
      nbit_d = nbit_q;
      idx_d = idx_q;
      cont_d = cont_q;
      cont_opc_d = cont_opc_q;
      in_cont_d = in_cont_q;
      run_d = run_q;
      ones_d = ones_q;
      buf_d = buf_q;
      loaded_d = loaded_q;
      w = 3'h1;
      lim = `RST_QUAD;
      if (fresh_q) begin
         ph_d = cont_q ? L_ADDR : L_OPC;
         frm_d = '0;
         frm_d.opc = cont_q ? cont_opc_q : 8'h00;
         acc_d = 24'h000000;
         nbit_d = 5'h00;
         in_cont_d = cont_q;
         run_d = 1'b1;
         ones_d = 5'h00;
      end
      w = lanes(frm_d.opc, ph_d);
      case (w)
         3'h4: acc_d = {acc_d[19:0], io_in};
         3'h2: acc_d = {acc_d[21:0], io_in[1:0]};
         default: acc_d = {acc_d[22:0], io_in[0]};
      endcase
      nbit_d = nbit_d + {2'h0, w};
      // all-ones run from frame start drops continuous mode
      run_d = run_d & io_in[0];
      if (run_d && ones_d != 5'h1F) begin
         ones_d = ones_d + 5'h01;
      end
      if (cont_opc_q == `OPC_DREAD) begin
         lim = `RST_DUAL;
      end
      if (in_cont_d && run_d && ones_d == lim && !bsy_s2_q) begin
         cont_d = 1'b0;
      end
      case (ph_d)
         L_OPC: begin
            if (nbit_d == `OPC_BITS) begin
               frm_d.opc = acc_d[7:0];
               nbit_d = 5'h00;
               case (acc_d[7:0])
                  `OPC_WREN, `OPC_WRDI: begin
                     ph_d = L_END;
                     frm_d.ok = 1'b1;
                  end
                  `OPC_PROG, `OPC_QPROG, `OPC_SERASE, `OPC_WRAP,
                  `OPC_DREAD, `OPC_QREAD, `OPC_WREAD,
                  `OPC_OREAD: ph_d = L_ADDR;
                  default: ph_d = L_SKIP;
               endcase
            end
         end
         L_ADDR: begin
            if (nbit_d == `ADDR_BITS) begin
               frm_d.addr = acc_d;
               idx_d = acc_d[7:0];
               nbit_d = 5'h00;
               if (frm_d.opc == `OPC_SERASE) begin
                  ph_d = L_END;
                  frm_d.ok = 1'b1;
               end else if (frm_d.opc == `OPC_PROG ||
                  frm_d.opc == `OPC_QPROG) begin
                  ph_d = L_DATA;
                  // busy level is settled here, unlike at frame start
                  if (!bsy_s2_q) begin
                     loaded_d = '0;
                  end
               end else begin
                  ph_d = L_MODE; // address done, mode or wrap byte next
               end
            end
         end
         L_MODE: begin
            if (nbit_d == `MODE_BITS) begin
               nbit_d = 5'h00;
               if (frm_d.opc == `OPC_WRAP) begin
                  frm_d.wrap_byte = acc_d[7:0];
                  frm_d.ok = 1'b1;
                  ph_d = L_END;
               end else begin
                  ph_d = L_SKIP;
                  if (!bsy_s2_q) begin
                     // only the two control bits count
                     cont_d = acc_d[`CTRL_LSB+1:`CTRL_LSB] ==
                        `CONT_KEEP;
                     cont_opc_d = frm_d.opc;
                  end
               end
            end
         end
         L_DATA: begin
            if (nbit_d == `DATA_BITS) begin
               nbit_d = 5'h00;
               frm_d.ok = 1'b1;
               if (!bsy_s2_q) begin
                  buf_d[idx_d] = acc_d[7:0];
                  loaded_d[idx_d] = 1'b1;
               end
               idx_d = idx_d + 8'h01;
            end else begin
               frm_d.ok = 1'b0;
            end
         end
         L_END: begin
            frm_d.ok = 1'b0;
            ph_d = L_SKIP;
         end
         L_SKIP: begin
            nbit_d = 5'h00;
         end
         default: ph_d = L_SKIP;
      endcase
   end

   // link decoder registers
   always_ff @(posedge link_sclk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q <= L_SKIP;
         frm_q <= '0;
         acc_q <= 24'h000000;
         nbit_q <= 5'h00;
         idx_q <= 8'h00;
         cont_q <= 1'b0;
         cont_opc_q <= 8'h00;
         in_cont_q <= 1'b0;
         run_q <= 1'b0;
         ones_q <= 5'h00;
         loaded_q <= '0;
      end else begin
         ph_q <= ph_d;
         frm_q <= frm_d;
         acc_q <= acc_d;
         nbit_q <= nbit_d;
         idx_q <= idx_d;
         cont_q <= cont_d;
         cont_opc_q <= cont_opc_d;
         in_cont_q <= in_cont_d;
         run_q <= run_d;
         ones_q <= ones_d;
         loaded_q <= loaded_d;
      end
   end

   // page buffer storage, no reset needed for data
   always_ff @(posedge link_sclk) begin
      buf_q <= buf_d;
   end

   // chip select and mode level brought into the core domain
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         cr_s1_q <= 1'b0;
         cont_read_active_q <= 1'b0;
      end else begin
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         cr_s1_q <= cont_q;
         cont_read_active_q <= cr_s1_q;
      end
   end

   // frame end; link registers stand still once sclk has stopped
   assign cs_rise = cs_s2_q & ~cs_s3_q;
   assign prot_hit = is_prot(frm_q.addr, protect);

   // command commit and self-timed cycle
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      wel_d = write_enable_latch_q;
      wrap_d = wrap_setting_q;
      cmd_d = cmd_q;
      cmd_d.prog = 1'b0;
      cmd_d.erase = 1'b0;
      done_d = 1'b0;
      case (st_q)
         C_IDLE: begin
            if (cs_rise && frm_q.ok) begin
               case (frm_q.opc)
                  `OPC_WREN: wel_d = 1'b1;
                  `OPC_WRDI: wel_d = 1'b0;
                  `OPC_WRAP: begin
                     // bits 6..4 only
                     wrap_d = frm_q.wrap_byte[`WRAP_LSB+2:`WRAP_LSB];
                  end
                  `OPC_PROG, `OPC_QPROG: begin
                     if (write_enable_latch_q && !prot_hit &&
                        (frm_q.opc == `OPC_PROG ||
                        quad_enable_bit)) begin
                        st_d = C_BUSY;
                        busy_d = 1'b1;
                        cnt_d = PROG_CYCLES[23:0];
                        cmd_d.prog = 1'b1;
                        cmd_d.addr = frm_q.addr;
                     end
                  end
                  `OPC_SERASE: begin
                     if (write_enable_latch_q && !prot_hit) begin
                        st_d = C_BUSY;
                        busy_d = 1'b1;
                        cnt_d = ERASE_CYCLES[23:0];
                        cmd_d.erase = 1'b1;
                        cmd_d.addr = frm_q.addr & `SECTOR_MASK;
                     end
                  end
                  default: wel_d = write_enable_latch_q;
               endcase
            end
         end
         C_BUSY: begin
            // frames seen now are dropped
            if (cnt_q <= 24'h000001) begin
               st_d = C_IDLE;
               busy_d = 1'b0;
               wel_d = 1'b0;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 24'h000001;
            end
         end
         default: st_d = C_IDLE;
      endcase
   end

   // command registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= C_IDLE;
         cnt_q <= 24'h000000;
         busy_q <= 1'b0;
         write_enable_latch_q <= 1'b0;
         wrap_setting_q <= `WRAP_RST;
         cmd_q <= '0;
         op_done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         write_enable_latch_q <= wel_d;
         wrap_setting_q <= wrap_d;
         cmd_q <= cmd_d;
         op_done_q <= done_d;
      end
   end

   // read address stepping with optional section wrap
   always_comb begin
      logic [23:0] mask;
      logic [23:0] inc;
      mask = 24'(({1'b0, 7'h08} << wrap_setting_q[2:1]) - 8'h01);
      inc = rd_addr_q + 24'h000001;
      rd_addr_d = rd_addr_q;
      if (rd_start) begin
         rd_addr_d = rd_start_addr;
      end else if (rd_next) begin
         if (wrap_setting_q[0]) begin
            rd_addr_d = inc;
         end else begin
            rd_addr_d = (rd_addr_q & ~mask) | (inc & mask);
         end
      end
   end

   // page buffer readout for the array, stable while busy
   always_comb begin
      buf_data_d = buf_q[buf_idx];
      buf_loaded_d = loaded_q[buf_idx];
   end

   // readout registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_addr_q <= 24'h000000;
         buf_data_q <= 8'h00;
         buf_loaded_q <= 1'b0;
      end else begin
         rd_addr_q <= rd_addr_d;
         buf_data_q <= buf_data_d;
         buf_loaded_q <= buf_loaded_d;
      end
   end

endmodule

/* File: flash_cmd_properties.sv */
// concurrent checks on the ports of the flash instruction block
`timescale 1ns/1ps
module flash_cmd_properties
   import flash_cmd_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = 20,
   parameter int unsigned ERASE_CYCLES = 40
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rd_start,
   input wire logic [23:0] rd_start_addr,
   input wire logic rd_next,
   input wire logic busy_q,
   input wire logic write_enable_latch_q,
   input wire logic [2:0] wrap_setting_q,
   input wire array_cmd_s cmd_q,
   input wire logic op_done_q,
   input wire logic [23:0] rd_addr_q
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic er_q;
   logic er_d;

   // length of the busy period and kind of the running operation
   always_comb begin
      cnt_d = busy_q ? cnt_q + 32'h1 : 32'h0;
      er_d = cmd_q.erase ? 1'h1 : (cmd_q.prog ? 1'h0 : er_q);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 32'h0;
         er_q <= 1'h0;
      end else begin
         cnt_q <= cnt_d;
         er_q <= er_d;
      end
   end

   // next read address, wrapping inside the section when enabled
   function automatic logic [23:0] nxt(input logic [23:0] a,
                                       input logic [2:0] w);
      logic [23:0] m;
      m = (24'h8 << w[2:1]) - 24'h1;
      return w[0] ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
   endfunction

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_launch;
      $rose(busy_q) && (cmd_q.prog || cmd_q.erase);
   endsequence
   sequence s_finish;
      $fell(busy_q) && op_done_q;
   endsequence

   property p_reset_vals;
      $rose(reset_n) |-> wrap_setting_q == 3'h7 && !write_enable_latch_q;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
   property p_launch;
      $rose(busy_q) |-> (cmd_q.prog || cmd_q.erase) && write_enable_latch_q;
   endproperty
   a_launch: assert property (p_launch) else $error("busy without command");
   property p_pulse;
      s_launch |=> busy_q && !cmd_q.prog && !cmd_q.erase;
   endproperty
   a_pulse: assert property (p_pulse) else $error("command pulse too long");
   property p_len;
      $fell(busy_q) |-> cnt_q == (er_q ? ERASE_CYCLES : PROG_CYCLES);
   endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   property p_done;
      $fell(busy_q) |-> op_done_q && !write_enable_latch_q;
   endproperty
   a_done: assert property (p_done) else $error("latch not cleared at end");
   property p_done_once;
      s_finish |=> !op_done_q && !busy_q;
   endproperty
   a_done_once: assert property (p_done_once) else $error("done too long");
   property p_hold_wel;
      busy_q |-> write_enable_latch_q;
   endproperty
   a_hold_wel: assert property (p_hold_wel) else $error("latch lost in busy");
   property p_quiet;
      busy_q && !$rose(busy_q) |-> !cmd_q.prog && !cmd_q.erase;
   endproperty
   a_quiet: assert property (p_quiet) else $error("command while busy");
   property p_wrap_hold;
      busy_q |=> $stable(wrap_setting_q);
   endproperty
   a_wrap_hold: assert property (p_wrap_hold) else $error("wrap changed busy");
   property p_rd_load;
      rd_start |=> rd_addr_q == $past(rd_start_addr);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read start wrong");
   property p_rd_step;
      rd_next && !rd_start |=>
         rd_addr_q == nxt($past(rd_addr_q), $past(wrap_setting_q));
   endproperty
   a_rd_step: assert property (p_rd_step) else $error("read step wrong");
endmodule

bind flash_cmd flash_cmd_properties #(
   .PROG_CYCLES(PROG_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES)
) flash_cmd_properties_i (
   .clk(clk), .reset_n(reset_n), .rd_start(rd_start),
   .rd_start_addr(rd_start_addr), .rd_next(rd_next), .busy_q(busy_q),
   .write_enable_latch_q(write_enable_latch_q),
   .wrap_setting_q(wrap_setting_q), .cmd_q(cmd_q), .op_done_q(op_done_q),
   .rd_addr_q(rd_addr_q)
);

/* File: spi_host_model.sv */
// host controller model that drives the serial link
`timescale 1ns/1ps
module spi_host_model (
   output logic link_sclk,
   output logic cs_n,
   output logic [3:0] io_in
);
   // clock parked low and device deselected until a frame starts
   initial begin
      link_sclk = 1'h0;
      cs_n = 1'h1;
      io_in = 4'h5;
   end

   // select the device at a phase unrelated to the core clock
   task automatic cs_lo();
      #7;
      cs_n = 1'h0;
      #32;
   endtask

   // n clocks of b msb first; data changes after the falling edge
   task automatic clocks(input logic [7:0] b, input int lanes, input int n);
      logic [7:0] s;
      s = b;
      for (int i = 0; i < n; i++) begin
         case (lanes)
            4: io_in = s[7:4];
            2: io_in = {s[7:6], s[7:6]};
            default: io_in = {4{s[7]}};
         endcase
         s = s << lanes;
         #32;
         link_sclk = 1'h1;
         #32;
         link_sclk = 1'h0;
      end
   endtask

   // deselect with the clock stopped; idle lines show a changed value
   task automatic cs_hi();
      #16;
      cs_n = 1'h1;
      io_in = ~io_in;
      #200;
   endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the flash instruction block
`timescale 1ns/1ps
module tb_top
   import flash_cmd_pkg::*;
;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic link_sclk;
   logic cs_n;
   logic [3:0] io_in;
   logic quad_enable_bit = 1'h0;
   protect_s protect = '0;
   logic [7:0] buf_idx = 8'h00;
   logic rd_start = 1'h0;
   logic [23:0] rd_start_addr = 24'h000000;
   logic rd_next = 1'h0;
   logic busy_q;
   logic write_enable_latch_q;
   logic [2:0] wrap_setting_q;
   logic cont_read_active_q;
   array_cmd_s cmd_q;
   logic op_done_q;
   logic [23:0] rd_addr_q;
   logic [7:0] buf_data_q;
   logic buf_loaded_q;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;

   always #12.5 clk = ~clk;

   flash_cmd #(.PROG_CYCLES(200), .ERASE_CYCLES(300)) flash_cmd_i (
      .clk(clk), .reset_n(reset_n), .link_sclk(link_sclk), .cs_n(cs_n),
      .io_in(io_in), .quad_enable_bit(quad_enable_bit), .protect(protect),
      .buf_idx(buf_idx), .rd_start(rd_start), .rd_start_addr(rd_start_addr),
      .rd_next(rd_next), .busy_q(busy_q),
      .write_enable_latch_q(write_enable_latch_q),
      .wrap_setting_q(wrap_setting_q),
      .cont_read_active_q(cont_read_active_q), .cmd_q(cmd_q),
      .op_done_q(op_done_q), .rd_addr_q(rd_addr_q),
      .buf_data_q(buf_data_q), .buf_loaded_q(buf_loaded_q));
   spi_host_model spi_host_model_i (
      .link_sclk(link_sclk), .cs_n(cs_n), .io_in(io_in));

   // verdict and end of run
   task automatic summarize();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // compare one value and count it
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one host frame; an opcode or address lane count of 0 leaves that phase out
   task automatic frm(input logic [7:0] op, input int ol,
                      input logic [23:0] a, input int al,
                      input logic [23:0] d, input int nd, input int dl,
                      input int xb);
      spi_host_model_i.cs_lo();
      if (ol != 0) begin
         spi_host_model_i.clocks(op, ol, 8 / ol);
      end
      for (int i = 2; i >= 0 && al != 0; i--) begin
         spi_host_model_i.clocks(a[i*8 +: 8], al, 8 / al);
      end
      for (int i = 0; i < nd; i++) begin
         spi_host_model_i.clocks(d[23 - 8*i -: 8], dl, 8 / dl);
      end
      if (xb != 0) begin
         spi_host_model_i.clocks(8'hFF, 1, xb);
      end
      spi_host_model_i.cs_hi();
      @(posedge clk);
      #1;
   endtask

   task automatic wren();
      frm(8'h06, 1, 24'h0, 0, 24'h0, 0, 1, 0);
   endtask

   // wait for the self-timed period to end, bounded
   task automatic idle();
      for (int i = 0; i < 400 && busy_q !== 1'h0; i++) begin
         @(posedge clk);
      end
      #1;
   endtask

   // load a read address then step it n times back to back
   task automatic walk(input logic [23:0] a, input int n);
      @(posedge clk);
      rd_start <= 1'h1;
      rd_start_addr <= a;
      @(posedge clk);
      rd_start <= 1'h0;
      rd_next <= 1'h1;
      repeat (n) @(posedge clk);
      rd_next <= 1'h0;
      @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      chk(24'(wrap_setting_q), 24'h7);
      chk(24'({busy_q, write_enable_latch_q}), 24'h0);
      frm(8'hFF, 1, 24'h0, 0, 24'h0, 0, 1, 0);
      chk(24'(cont_read_active_q), 24'h0);
      $display("test reset done");
   endtask

   task automatic t_wrap();
      for (int n = 0; n < 4; n++) begin
         frm(8'h77, 1, 24'h0, 4, {1'h1, 2'(n), 5'h0A, 16'h0}, 1, 4, 0);
         chk(24'(wrap_setting_q), 24'(n * 2));
         walk(24'h001235, 8 << n);
         chk(rd_addr_q, 24'h001235);
      end
      walk(24'h2F3C9A, 64);
      chk(rd_addr_q, 24'h2F3C9A);
      frm(8'h77, 1, 24'h0, 4, 24'h100000, 1, 4, 0);
      chk(24'(wrap_setting_q), 24'h1);
      walk(24'h001235, 64);
      chk(rd_addr_q, 24'h001275);
      $display("test wrap done");
   endtask

   task automatic t_prog();
      logic [7:0] bd [4] = '{8'hA1, 8'hB2, 8'hC3, 8'h00};
      frm(8'h02, 1, 24'h0012FE, 1, 24'hA10000, 1, 1, 0);
      chk(24'(busy_q), 24'h0);
      wren();
      chk(24'(write_enable_latch_q), 24'h1);
      frm(8'h02, 1, 24'h0012FE, 1, 24'hA1B2C3, 3, 1, 0);
      chk(24'(busy_q), 24'h1);
      chk(cmd_q.addr, 24'h0012FE);
      frm(8'h77, 1, 24'h0, 4, 24'h000000, 1, 4, 0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         buf_idx <= 8'hFE + 8'(i);
         repeat (2) @(posedge clk);
         #1;
         chk(24'({buf_loaded_q, (i < 3) ? buf_data_q : 8'h00}),
             24'({i < 3, bd[i]}));
      end
      idle();
      chk(24'({busy_q, write_enable_latch_q}), 24'h0);
      chk(24'(wrap_setting_q), 24'h1);
      $display("test program done");
   endtask

   task automatic t_cancel();
      wren();
      frm(8'h02, 1, 24'h000100, 1, 24'h550000, 1, 1, 1);
      chk(24'(busy_q), 24'h0);
      frm(8'h20, 1, 24'h012345, 1, 24'h0, 0, 1, 4);
      chk(24'(busy_q), 24'h0);
      frm(8'h20, 1, 24'h012345, 1, 24'h0, 0, 1, 0);
      chk(24'(busy_q), 24'h1);
      chk(cmd_q.addr, 24'h012000);
      idle();
      chk(24'(write_enable_latch_q), 24'h0);
      $display("test cancel done");
   endtask

   task automatic t_protect();
      @(posedge clk);
      protect.block_protect_low <= 1'h1;
      wren();
      frm(8'h20, 1, 24'h3F1000, 1, 24'h0, 0, 1, 0);
      chk(24'(busy_q), 24'h0);
      frm(8'h20, 1, 24'h3E1000, 1, 24'h0, 0, 1, 0);
      chk(24'(busy_q), 24'h1);
      idle();
      @(posedge clk);
      protect.protect_complement_bit <= 1'h1;
      wren();
      frm(8'h20, 1, 24'h3E1000, 1, 24'h0, 0, 1, 0);
      chk(24'(busy_q), 24'h0);
      @(posedge clk);
      protect <= '0;
      $display("test protect done");
   endtask

   task automatic t_quad();
      wren();
      frm(8'h32, 1, 24'h000200, 4, 24'h5A0000, 1, 4, 0);
      chk(24'(busy_q), 24'h0);
      @(posedge clk);
      quad_enable_bit <= 1'h1;
      frm(8'h32, 1, 24'h000200, 4, 24'h5A0000, 1, 4, 0);
      chk(24'(busy_q), 24'h1);
      chk(cmd_q.addr, 24'h000200);
      idle();
      $display("test quad done");
   endtask

   task automatic t_cont();
      logic [7:0] op [6] = '{8'hE7, 8'hFF, 8'hEB, 8'h00, 8'hBB, 8'h00};
      int ol [6] = '{1, 1, 1, 0, 1, 0};
      int al [6] = '{4, 0, 4, 4, 2, 0};
      logic [23:0] d [6] = '{24'h2F0000, 24'h0, 24'hEF0000, 24'h300000,
                             24'h200000, 24'hFFFF00};
      int nd [6] = '{1, 0, 1, 1, 1, 2};
      int dl [6] = '{4, 1, 4, 4, 2, 1};
      for (int i = 0; i < 6; i++) begin
         frm(op[i], ol[i], 24'h000100, al[i], d[i], nd[i], dl[i], 0);
         chk(24'(cont_read_active_q), 24'(i % 2 == 0));
      end
      $display("test continuous done");
   endtask

   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         summarize();
      end
   end

   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_wrap();
      t_prog();
      t_cancel();
      t_protect();
      t_quad();
      t_cont();
      summarize();
   end
endmodule
